// [hsbi_pkg.sv]
/*
 host system bus interface package: timing counts, bus-cycle states,
 address layout and lane helpers.
 assumes a single 25 MHz system clock and no software-visible registers.
*/
package hsbi_pkg;

    localparam int          SYS_CLK_MHZ     = 25;
    localparam int          ADDR_W          = 32;
    localparam int          DATA_W          = 16;
    localparam int          REG_SEL_W       = 4;
    localparam int          NUM_REGS        = 16;
    localparam logic [7:0]  BYTE_RST        = 8'h00;
    localparam logic [15:0] WORD_RST        = 16'h0000;
    localparam logic [31:0] ADDR_RST        = 32'h0000_0000;
    localparam logic [15:0] LOW_CARRY_MASK  = 16'hFFFF;
    localparam logic [31:0] WORD_STEP       = 32'h0000_0002;
    localparam logic [31:0] BYTE_STEP       = 32'h0000_0001;
    localparam logic [15:0] COUNT_RST       = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_REQ,
        ST_ARB,
        ST_XAL,
        ST_ALE,
        ST_DATA,
        ST_STROBE,
        ST_END,
        ST_RELEASE
    } dma_state_type;

    // bit reversal: lane index zero carries the byte's most significant bit
    function automatic logic [7:0] to_lane(input logic [7:0] b);
        logic [7:0] r;
        r = BYTE_RST;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7 - i];
        end
        return r;
    endfunction

    // odd parity over one byte
    function automatic logic odd_par(input logic [7:0] b);
        return ~(^b);
    endfunction

endpackage

// [hsbi_sync.sv]
/*
 two flip-flop synchroniser with rising and falling edge outputs.
 assumes the input comes from outside the sys_clk domain.
*/
`timescale 1ns/1ps
module hsbi_sync
    import hsbi_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out,
    output logic      rise,
    output logic      fall
);

    logic meta_r;
    logic sync_r;
    logic last_r;

    // only sync_r reads meta_r
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
            last_r <= RST_VAL;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign sync_out = sync_r;
    assign rise     = sync_r & ~last_r;
    assign fall     = ~sync_r & last_r;

endmodule

// [host_system_bus_interface.sv]
/*
 host system bus interface, device side: direct i/o slave writes into a
 register file and a bus-master dma engine clocked by host_bus_clk edges.
 assumes all pins arrive asynchronously, two-way pins are split into
 in/out/oe, and the dma requester holds dma_start until dma_done.
*/
// Contract
// RULE_01: write strobe direction follows transfer type
// RULE_02: direct write latched on strobe rising edge
// RULE_03: dma write drives strobe low with data
// RULE_04: extended latch pulse per block and carry
// RULE_05: upper address parity shown during extended latch
// RULE_06: reset edge latches dma width; live io width
// RULE_07: high lane carries high address/data bytes
// RULE_08: low lane carries low address/data bytes
// RULE_09: address latch pulse starts each dma cycle
// RULE_10: take bus only when not busy, granted
// RULE_11: dma timing follows host bus clock
// RULE_12: read_not_write high read, driven by master
// RULE_13: release request ends bus tenure after cycle
// RULE_14: host chip select gates direct i/o
// RULE_15: data buffer enable low during transfers
// RULE_16: bus request asserted before dma
// RULE_17: grant is synchronised, low means granted
// RULE_18: drive address and strobes only as master
`timescale 1ns/1ps
module host_system_bus_interface
    import hsbi_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 system_reset_n,
    input  wire logic                 host_bus_clk,
    input  wire logic                 chip_select_n,
    input  wire logic [REG_SEL_W-1:0] reg_sel,
    input  wire logic                 bus_width_sel,
    input  wire logic                 bus_busy_in,
    input  wire logic                 bus_release_req,
    input  wire logic                 bus_grant_n,
    output logic                      bus_request_n,
    input  wire logic                 write_strobe_n_in,
    output logic                      write_strobe_n_out,
    output logic                      write_strobe_n_oe,
    input  wire logic                 read_not_write_in,
    output logic                      read_not_write_out,
    output logic                      read_not_write_oe,
    input  wire logic [7:0]           ad_high_lane_in,
    output logic      [7:0]           ad_high_lane_out,
    output logic                      ad_high_lane_oe,
    input  wire logic [7:0]           ad_low_lane_in,
    output logic      [7:0]           ad_low_lane_out,
    output logic                      ad_low_lane_oe,
    output logic                      parity_high_out,
    output logic                      parity_low_out,
    output logic                      parity_oe,
    output logic                      ext_addr_latch,
    output logic                      addr_latch_en,
    output logic                      data_buf_en_n,
    input  wire logic                 addr_parity_en,
    input  wire logic                 dma_start,
    input  wire logic [ADDR_W-1:0]    dma_addr,
    input  wire logic [15:0]          dma_count,
    input  wire logic [DATA_W-1:0]    dma_wdata,
    output logic                      dma_wdata_take,
    output logic                      dma_done,
    output logic                      dma_width_8,
    output logic                      dio_width_8,
    output logic [DATA_W-1:0]         dio_reg_data,
    input  wire logic [REG_SEL_W-1:0] dio_reg_rd_sel
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic cs_n_s, wr_n_s, wr_rise, bclk_s, bclk_rise, bclk_fall, sres_rise;
    logic busy_s, rls_s, gnt_s, bw_s, rnw_s;
    logic [7:0] adh_m_r, adh_s_r, adl_m_r, adl_s_r;
    logic [REG_SEL_W-1:0] sel_m_r, sel_s_r;

    hsbi_sync u_cs   (.sys_clk(sys_clk), .rst(rst), .async_in(chip_select_n),
                      .sync_out(cs_n_s), .rise(), .fall());
    hsbi_sync u_wr   (.sys_clk(sys_clk), .rst(rst), .async_in(write_strobe_n_in),
                      .sync_out(wr_n_s), .rise(wr_rise), .fall());
    hsbi_sync u_bclk (.sys_clk(sys_clk), .rst(rst), .async_in(host_bus_clk),
                      .sync_out(bclk_s), .rise(bclk_rise), .fall(bclk_fall));
    hsbi_sync u_sres (.sys_clk(sys_clk), .rst(rst), .async_in(system_reset_n),
                      .sync_out(), .rise(sres_rise), .fall());
    hsbi_sync u_busy (.sys_clk(sys_clk), .rst(rst), .async_in(bus_busy_in),
                      .sync_out(busy_s), .rise(), .fall());
    hsbi_sync u_rls  (.sys_clk(sys_clk), .rst(rst), .async_in(bus_release_req),
                      .sync_out(rls_s), .rise(), .fall());
    hsbi_sync u_gnt  (.sys_clk(sys_clk), .rst(rst), .async_in(bus_grant_n),
                      .sync_out(gnt_s), .rise(), .fall());
    hsbi_sync u_bw   (.sys_clk(sys_clk), .rst(rst), .async_in(bus_width_sel),
                      .sync_out(bw_s), .rise(), .fall());
    hsbi_sync u_rnw  (.sys_clk(sys_clk), .rst(rst), .async_in(read_not_write_in),
                      .sync_out(rnw_s), .rise(), .fall());

    // data and select lanes, two stages each
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            adh_m_r <= BYTE_RST;
            adh_s_r <= BYTE_RST;
            adl_m_r <= BYTE_RST;
            adl_s_r <= BYTE_RST;
            sel_m_r <= '0;
            sel_s_r <= '0;
        end else begin
            adh_m_r <= ad_high_lane_in;
            adh_s_r <= adh_m_r;
            adl_m_r <= ad_low_lane_in;
            adl_s_r <= adl_m_r;
            sel_m_r <= reg_sel;
            sel_s_r <= sel_m_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus width: latched at reset release, live for direct i/o

    logic dma_w8_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dma_w8_r <= 1'b1;
        end else if (sres_rise) begin
            dma_w8_r <= bw_s;                            // RULE_06
        end
    end

    assign dma_width_8 = dma_w8_r;
    assign dio_width_8 = bw_s;                          // RULE_06

    ////////////////////////////////////////////////////////////////////////
    // direct i/o write into the register file

    logic [DATA_W-1:0] regs_r [NUM_REGS];
    logic              dio_sel;
    logic              dio_wr;
    logic [15:0]       dio_word;

    assign dio_sel  = ~cs_n_s;                          // RULE_14
    assign dio_wr   = dio_sel & wr_rise & ~rnw_s;
    assign dio_word = {to_lane(adh_s_r), to_lane(adl_s_r)};  // RULE_07 RULE_08

    // capture on rising strobe edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= WORD_RST;
            end
        end else if (dio_wr) begin
            if (bw_s) begin
                regs_r[sel_s_r][7:0] <= to_lane(adl_s_r);
            end else begin
                regs_r[sel_s_r] <= dio_word;             // RULE_02
            end
        end
    end

    assign dio_reg_data = regs_r[dio_reg_rd_sel];

    ////////////////////////////////////////////////////////////////////////
    // dma engine, stepped on host bus clock edges

    dma_state_type       state_r, state_nxt;
    logic [ADDR_W-1:0]   addr_r, addr_nxt;
    logic [15:0]         left_r, left_nxt;
    logic [DATA_W-1:0]   data_r, data_nxt;
    logic                first_r, first_nxt;
    logic [ADDR_W-1:0]   addr_inc;
    logic                carry;
    logic                owner;
    logic                step;

    assign step     = bclk_rise;                        // RULE_11
    assign addr_inc = addr_r + (dma_w8_r ? BYTE_STEP : WORD_STEP);
    assign carry    = addr_inc[31:16] != addr_r[31:16];
    assign owner    = (state_r != ST_IDLE) && (state_r != ST_REQ)
                   && (state_r != ST_ARB) && (state_r != ST_RELEASE);   // RULE_18

    // next state of the dma sequencer
    always_comb begin
        state_nxt = state_r;
        addr_nxt  = addr_r;
        left_nxt  = left_r;
        data_nxt  = data_r;
        first_nxt = first_r;
        case (state_r)
            ST_IDLE: begin
                if (dma_start && dma_count != COUNT_RST) begin
                    addr_nxt  = dma_addr;
                    left_nxt  = dma_count;
                    first_nxt = 1'b1;
                    state_nxt = ST_REQ;
                end
            end
            ST_REQ: begin
                if (step) begin
                    state_nxt = ST_ARB;                  // RULE_16
                end
            end
            ST_ARB: begin
                if (step && !gnt_s && busy_s) begin      // RULE_10 RULE_17
                    state_nxt = first_r ? ST_XAL : ST_ALE;
                end
            end
            ST_XAL: begin
                if (step) begin
                    first_nxt = 1'b0;
                    state_nxt = ST_ALE;                  // RULE_04
                end
            end
            ST_ALE: begin
                if (step) begin
                    data_nxt  = dma_wdata;
                    state_nxt = ST_DATA;                 // RULE_09
                end
            end
            ST_DATA: begin
                if (step) begin
                    state_nxt = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (step) begin
                    addr_nxt  = addr_inc;
                    left_nxt  = left_r - 16'h0001;
                    first_nxt = carry;                   // RULE_04
                    state_nxt = ST_END;
                end
            end
            // carry was judged before the address moved
            ST_END: begin
                if (left_r == COUNT_RST) begin
                    state_nxt = ST_RELEASE;
                end else if (!rls_s) begin
                    state_nxt = ST_REQ;                  // RULE_13
                end else begin
                    state_nxt = first_r ? ST_XAL : ST_ALE; // RULE_04
                end
            end
            ST_RELEASE: begin
                if (!dma_start) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // dma state registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            addr_r  <= ADDR_RST;
            left_r  <= COUNT_RST;
            data_r  <= WORD_RST;
            first_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r  <= addr_nxt;
            left_r  <= left_nxt;
            data_r  <= data_nxt;
            first_r <= first_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive

    logic        drive_xal, drive_ale, drive_data;
    logic [7:0]  hi_byte, lo_byte;

    assign drive_xal  = state_r == ST_XAL;
    assign drive_ale  = state_r == ST_ALE;
    assign drive_data = (state_r == ST_DATA) || (state_r == ST_STROBE)
                     || (state_r == ST_END);

    // byte selection per phase
    assign hi_byte = drive_xal ? addr_r[31:24]
                   : drive_ale ? addr_r[15:8] : data_r[15:8];    // RULE_07
    assign lo_byte = drive_xal ? addr_r[23:16]
                   : drive_ale ? addr_r[7:0] : data_r[7:0];      // RULE_08

    // registered pin outputs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ad_high_lane_out   <= BYTE_RST;
            ad_low_lane_out    <= BYTE_RST;
            parity_high_out    <= 1'b1;
            parity_low_out     <= 1'b1;
            ext_addr_latch     <= 1'b0;
            addr_latch_en      <= 1'b0;
            write_strobe_n_out <= 1'b1;
        end else begin
            ad_high_lane_out   <= to_lane(hi_byte);
            ad_low_lane_out    <= to_lane(lo_byte);
            parity_high_out    <= odd_par(hi_byte);                  // RULE_05
            parity_low_out     <= odd_par(lo_byte);                  // RULE_05
            // no second pulse on the edge that leaves the phase
            ext_addr_latch     <= drive_xal & bclk_s & ~step;        // RULE_04
            addr_latch_en      <= drive_ale & bclk_s & ~step;        // RULE_09
            write_strobe_n_out <= ~(state_r == ST_STROBE);           // RULE_03
        end
    end

    assign write_strobe_n_oe  = owner;                               // RULE_01 RULE_18
    assign read_not_write_out = 1'b0;                                // RULE_12
    assign read_not_write_oe  = owner;                               // RULE_12 RULE_18
    assign ad_high_lane_oe    = owner;                               // RULE_18
    assign ad_low_lane_oe     = owner;                               // RULE_18
    assign parity_oe          = owner & addr_parity_en;              // RULE_05
    assign bus_request_n      = ~((state_r == ST_REQ) || (state_r == ST_ARB)); // RULE_16
    assign data_buf_en_n      = ~(drive_data | (dio_sel & ~wr_n_s)); // RULE_15
    assign dma_wdata_take     = (state_r == ST_ALE) & step;
    assign dma_done           = state_r == ST_RELEASE;

    // falling bus clock edge unused beyond synchroniser
    logic unused_fall;
    assign unused_fall = bclk_fall;

endmodule

// [hsbi_checker.sv]
/*
 concurrent checks on the host bus pins of host_system_bus_interface.
 assumes one sys_clk domain and a bind to the top module.
*/
`timescale 1ns/1ps
module hsbi_checker
    import hsbi_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       bus_width_sel,
    input wire logic       bus_busy_in,
    input wire logic       dma_start,
    input wire logic       bus_request_n,
    input wire logic       write_strobe_n_out,
    input wire logic       write_strobe_n_oe,
    input wire logic       read_not_write_out,
    input wire logic       read_not_write_oe,
    input wire logic [7:0] ad_high_lane_out,
    input wire logic [7:0] ad_low_lane_out,
    input wire logic       ad_high_lane_oe,
    input wire logic       ad_low_lane_oe,
    input wire logic       parity_high_out,
    input wire logic       parity_low_out,
    input wire logic       parity_oe,
    input wire logic       ext_addr_latch,
    input wire logic       addr_latch_en,
    input wire logic       data_buf_en_n,
    input wire logic       dio_width_8
);
    // every check runs on sys_clk and sleeps in reset
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // pin ownership, strobe shape, parity and width
    property p_strobe_own; !write_strobe_n_out |-> write_strobe_n_oe; endproperty
    a_strobe_own: assert property (p_strobe_own) else $error("strobe low undriven");
    property p_strobe_len;
        $fell(write_strobe_n_out) |-> (!write_strobe_n_out)[*7] ##[1:3] write_strobe_n_out;
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe length");
    property p_xal_first; $rose(dma_start) |-> ##[1:400] ext_addr_latch; endproperty
    a_xal_first: assert property (p_xal_first) else $error("no extended latch");
    property p_parity;
        ext_addr_latch && parity_oe |-> parity_high_out == ~(^ad_high_lane_out)
            && parity_low_out == ~(^ad_low_lane_out);
    endproperty
    a_parity: assert property (p_parity) else $error("upper parity wrong");
    property p_width; $stable(bus_width_sel)[*4] |-> dio_width_8 == bus_width_sel; endproperty
    a_width: assert property (p_width) else $error("io width not live");
    property p_ale_drive; addr_latch_en |-> ad_low_lane_oe && ad_high_lane_oe; endproperty
    a_ale_drive: assert property (p_ale_drive) else $error("latch with lanes free");
    property p_busy; (!bus_busy_in)[*8] |-> !$rose(write_strobe_n_oe); endproperty
    a_busy: assert property (p_busy) else $error("bus taken while busy");
    property p_rnw; read_not_write_oe |-> !read_not_write_out; endproperty
    a_rnw: assert property (p_rnw) else $error("direction not write");
    property p_req_free; !bus_request_n |-> !ad_low_lane_oe; endproperty
    a_req_free: assert property (p_req_free) else $error("lanes driven while asking");
    property p_buf; !write_strobe_n_out |-> !data_buf_en_n; endproperty
    a_buf: assert property (p_buf) else $error("buffers off in strobe");
    ////////////////////////////////////////////////////////////////////////////////
    // main scenarios reached
    c_xal: cover property (ext_addr_latch);
    c_strobe: cover property ($fell(write_strobe_n_out));
    c_width8: cover property (dio_width_8);
endmodule

bind host_system_bus_interface hsbi_checker u_hsbi_checker (.sys_clk, .rst, .bus_width_sel,
    .bus_busy_in, .dma_start, .bus_request_n, .write_strobe_n_out, .write_strobe_n_oe,
    .read_not_write_out, .read_not_write_oe, .ad_high_lane_out, .ad_high_lane_oe,
    .ad_low_lane_out, .parity_low_out,
    .ad_low_lane_oe, .parity_high_out, .parity_oe, .ext_addr_latch, .addr_latch_en,
    .data_buf_en_n, .dio_width_8);

// [hsbi_host_arbiter.sv]
/*
 host side model: free-running system bus clock and the bus arbiter.
 assumes the device asks with an active-low request.
*/
`timescale 1ns/1ps
module hsbi_host_arbiter (
    output logic            host_bus_clk,
    input  wire logic       bus_request_n,
    input  wire logic [3:0] grant_wait,
    output logic            bus_grant_n
);
    logic [3:0] wait_r;
    ////////////////////////////////////////////////////////////////////////////////
    // system bus clock, 320 ns period
    initial host_bus_clk = 1'b0;
    always #160 host_bus_clk = ~host_bus_clk;
    // grant low after grant_wait bus clocks of request, withdrawn with it
    initial bus_grant_n = 1'b1;
    initial wait_r = 4'h0;
    always @(negedge host_bus_clk) begin
        if (bus_request_n) begin
            bus_grant_n <= 1'b1;
            wait_r <= 4'h0;
        end else if (wait_r >= grant_wait) begin
            bus_grant_n <= 1'b0;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule

// [host_system_bus_interface_test.sv]
/*
 self-checking bench for host_system_bus_interface: direct writes and dma.
 assumes the package, checker and arbiter model are compiled first.
*/
`timescale 1ns/1ps
module host_system_bus_interface_test;
    import hsbi_pkg::*;
    logic        sys_clk = 1'b0, rst = 1'b1, system_reset_n = 1'b0, host_bus_clk;
    logic        chip_select_n = 1'b1, bus_width_sel = 1'b0, addr_parity_en = 1'b1;
    logic        bus_busy_in = 1'b1, bus_release_req = 1'b1, bus_grant_n, bus_request_n;
    logic        write_strobe_n_out, write_strobe_n_oe, read_not_write_out, read_not_write_oe;
    logic [7:0]  ad_high_lane_out, ad_low_lane_out;
    logic        ad_high_lane_oe, ad_low_lane_oe, parity_high_out, parity_low_out, parity_oe;
    logic        ext_addr_latch, addr_latch_en, data_buf_en_n, dma_start = 1'b0;
    logic        dma_wdata_take, dma_done, dma_width_8, dio_width_8;
    logic [31:0] dma_addr = 32'h0;
    logic [15:0] dma_count = 16'h0, dma_wdata = 16'h0, dio_reg_data, xv, av, dv;
    logic [3:0]  reg_sel = 4'h0, dio_reg_rd_sel = 4'h0, grant_wait = 4'h0;
    logic        h_drv = 1'b0, h_ws = 1'b1, h_rnw = 1'b1, xp = 1'b0, ap = 1'b0, wp = 1'b0;
    logic        rqp = 1'b1;
    logic [7:0]  h_hi = 8'hFF, h_lo = 8'hFF;
    logic [15:0] xq[$], aq[$], dq[$];
    int          nreq = 0, cyc = 0, n_errors = 0, tests_run = 0;

    function automatic logic [7:0] rv(input logic [7:0] b);
        return {<<{b}};
    endfunction
    // shared pins: device when enabled, else host, else pull-up
    wire logic       write_strobe_n_in = write_strobe_n_oe ? write_strobe_n_out : (h_drv ? h_ws : 1'b1);
    wire logic       read_not_write_in = read_not_write_oe ? read_not_write_out : (h_drv ? h_rnw : 1'b1);
    wire logic [7:0] ad_high_lane_in = ad_high_lane_oe ? ad_high_lane_out : (h_drv ? h_hi : 8'hFF);
    wire logic [7:0] ad_low_lane_in = ad_low_lane_oe ? ad_low_lane_out : (h_drv ? h_lo : 8'hFF);
    wire logic [15:0] lanes = {rv(ad_high_lane_in), rv(ad_low_lane_in)};

    host_system_bus_interface u_host_system_bus_interface (.*);
    hsbi_host_arbiter u_hsbi_host_arbiter (.host_bus_clk, .bus_request_n, .grant_wait, .bus_grant_n);

    always #20 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    // bus watcher: value at end of each latch pulse and strobe
    always @(negedge sys_clk) begin
        if (ext_addr_latch) xv = lanes;
        if (addr_latch_en) av = lanes;
        if (write_strobe_n_oe && !write_strobe_n_in) dv = lanes;
        if (xp && !ext_addr_latch) xq.push_back(xv);
        if (ap && !addr_latch_en) aq.push_back(av);
        if (wp && !(write_strobe_n_oe && !write_strobe_n_in)) dq.push_back(dv);
        if (rqp && !bus_request_n) nreq++;
        xp = ext_addr_latch;
        ap = addr_latch_en;
        wp = write_strobe_n_oe && !write_strobe_n_in;
        rqp = bus_request_n;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // host write cycle, strobe rising edge stores the data
    task automatic dio_write(input logic [3:0] s, input logic [15:0] d, input logic cs);
        h_drv = 1'b1;
        chip_select_n = cs;
        reg_sel = s;
        h_rnw = 1'b0;
        h_hi = rv(d[15:8]);
        h_lo = rv(d[7:0]);
        repeat (2) @(negedge sys_clk);
        h_ws = 1'b0;
        repeat (4) @(negedge sys_clk);
        check(data_buf_en_n === cs, "buffer enable in write");
        check(write_strobe_n_oe === 1'b0, "strobe taken by device");
        h_ws = 1'b1;
        repeat (6) @(negedge sys_clk);
        h_drv = 1'b0;
        chip_select_n = 1'b1;
        dio_reg_rd_sel = s;
        repeat (2) @(negedge sys_clk);
    endtask
    // one dma block; rel holds release low, bsy keeps the bus busy that long
    task automatic run_dma(input logic [31:0] a, input logic [15:0] n, input logic [3:0] gw,
                           input logic rel, input int bsy);
        logic [31:0] ad;
        int          k;
        int          xn;
        logic        tk;
        xq.delete();
        aq.delete();
        dq.delete();
        nreq = 0;
        grant_wait = gw;
        bus_release_req = !rel;
        dma_addr = a;
        dma_count = n;
        dma_wdata = 16'hA5C3;
        dma_start = 1'b1;
        k = 0;
        tk = 1'b0;
        while (dma_done !== 1'b1 && k < 3000) begin
            bus_busy_in = (k >= bsy);
            if (k == bsy - 1) check(ad_low_lane_oe === 1'b0, "bus taken while busy");
            @(negedge sys_clk);
            // next word only after the edge that took this one
            if (tk) dma_wdata = dma_wdata + 16'h1111;
            tk = (dma_wdata_take === 1'b1);
            k++;
        end
        check(dma_done === 1'b1, "dma did not finish");
        dma_start = 1'b0;
        bus_release_req = 1'b1;
        repeat (16) @(negedge sys_clk);
        check(ad_low_lane_oe === 1'b0 && data_buf_en_n === 1'b1, "bus kept");
        check(aq.size() == n && dq.size() == n, "cycle count");
        xn = 0;
        for (int i = 0; i < n; i++) begin
            ad = a + 32'(2 * i);
            if (i == 0 || ad[15:0] == 16'h0000) xn++;
            check(aq[i] === ad[15:0], "low address");
            check(dq[i] === 16'hA5C3 + 16'(i) * 16'h1111, "data word");
        end
        check(xq.size() == xn, "extended latch count");
        check(xq[0] === a[31:16] && xq[$] === ad[31:16], "upper address");
        check(nreq == (rel ? n : 1), "request count");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check(dma_width_8 === 1'b0, "dma width not latched");
        check(bus_request_n === 1'b1 && data_buf_en_n === 1'b1, "idle outputs");
        check(ad_low_lane_oe === 1'b0 && write_strobe_n_oe === 1'b0, "idle drive");
        bus_width_sel = 1'b1;
        repeat (5) @(negedge sys_clk);
        check(dio_width_8 === 1'b1 && dma_width_8 === 1'b0, "live width");
    endtask
    task automatic t_dio;
        dio_write(4'hF, 16'hA55A, 1'b0);
        check(dio_reg_data === 16'h005A, "byte write");
        bus_width_sel = 1'b0;
        dio_write(4'h5, 16'h3C81, 1'b0);
        check(dio_reg_data === 16'h3C81, "word write");
        dio_write(4'h5, 16'h7E00, 1'b1);
        check(dio_reg_data === 16'h3C81, "unselected write");
    endtask
    task automatic t_carry;
        run_dma(32'h1234_FFFE, 16'h0002, 4'h0, 1'b0, 0);
    endtask
    task automatic t_release;
        run_dma(32'h0000_0100, 16'h0003, 4'h3, 1'b1, 0);
    endtask
    task automatic t_busy;
        run_dma(32'h00AB_0010, 16'h0001, 4'h0, 1'b0, 80);
    endtask

    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        system_reset_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        t_reset();
        t_dio();
        t_carry();
        t_release();
        t_busy();
        conclude();
    end
endmodule
